// file: design/prbc_pkg.sv
/*
 Constants, types and state codes shared by the park, reset and boot
 control block. The block is assumed to sit on one 20 MHz clock, with
 its registers reached over AHB-Lite.
*/
// What this block does
// - park request low parks mirrors, no power-down
// - reset release rising edge starts self-configuration
// - outputs inactive while power-on reset asserted
// - fast park input parks the mirrors quickly
// - boot strap latched: low boots, high waits host
// - aux strap high also waits host; normal boot needs both straps low
package prbc_pkg;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int CONFIG_TIME_US = 50;
    localparam int NORMAL_PARK_TIME_US = 100;
    localparam int FAST_PARK_TIME_US = 10;
    localparam int CONFIG_CYC = CONFIG_TIME_US * CYC_PER_US;
    localparam int NORMAL_PARK_CYC = NORMAL_PARK_TIME_US * CYC_PER_US;
    localparam int FAST_PARK_CYC = FAST_PARK_TIME_US * CYC_PER_US;
    localparam int CNT_W = 16;

    // ---------------------------------------------------------------
    // register map, byte addresses within the slave window
    // ---------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_FAST_COUNT = 8'h08;
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_SOFT_PARK_BIT = 1;
    localparam logic CTRL_SOFT_PARK_RESET = 1'b0;
    localparam int ST_STATE_LSB = 0;
    localparam int ST_BOOT_MODE_BIT = 3;
    localparam int ST_BOOT_AUX_BIT = 4;
    localparam int ST_TEST_RST_BIT = 5;
    localparam int ST_DEBUG_SEL_BIT = 6;
    localparam int ST_SOFT_PARK_BIT = 7;

    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_OFF,
        ST_CONFIG,
        ST_WAIT_HOST,
        ST_RUN,
        ST_PARKING,
        ST_FAST_PARK,
        ST_PARKED
    } prbc_state_t;

    // asynchronous pins, carried together through the synchroniser
    typedef struct packed {
        logic park_request_n;
        logic power_on_reset_n;
        logic fast_park_n;
        logic boot_mode_strap;
        logic boot_aux_strap;
        logic test_port_reset_n;
        logic debug_mode_select;
    } prbc_pins_t;

    // captured address phase
    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
    } prbc_ahb_req_t;

endpackage : prbc_pkg

// file: design/prbc_sync.sv
/*
 Two-flop synchroniser for a vector of independent level inputs.
 Assumes each bit is a slow level; no bus coherence between bits.
*/
`timescale 1ns/1ps
`default_nettype none
module prbc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q <= '0;
        end else if (en) begin
            meta <= d;
            q <= meta;
        end
    end

    // the two edges after a reset release still look back into reset
    a_sync_depth: assert property (@(posedge clk) disable iff (!rst_n)
        ($past(rst_n, 2) && $past(en, 1) && $past(en, 2))
        |-> (q == $past(d, 2)))
        else $error("synchroniser output is not input delayed two cycles");

endmodule : prbc_sync
`default_nettype wire

// file: design/prbc_top.sv
/*
 Park, reset and boot control: tracks the power-on reset pin, runs
 self-configuration, reads boot straps and sequences normal and fast
 mirror parking. Assumes the park, reset, strap and debug pins are asynchronous to CLOCK and that an
 AHB-Lite master with a single slave drives the register port.
*/
`timescale 1ns/1ps
`default_nettype none
module prbc_top #(
    parameter int CONFIG_CYCLES = prbc_pkg::CONFIG_CYC,
    parameter int NORMAL_PARK_CYCLES = prbc_pkg::NORMAL_PARK_CYC,
    parameter int FAST_PARK_CYCLES = prbc_pkg::FAST_PARK_CYC
) (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic CLK_EN,
    input wire logic PARK_REQUEST_N,
    input wire logic POWER_ON_RESET_N,
    input wire logic FAST_PARK_N,
    input wire logic BOOT_MODE_STRAP,
    input wire logic BOOT_AUX_STRAP,
    input wire logic TEST_PORT_RESET_N,
    input wire logic DEBUG_MODE_SELECT,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    output logic MIRROR_PARK_BUSY,
    output logic MIRROR_PARKED,
    output logic FAST_PARK_BUSY,
    output logic SELF_CONFIG_BUSY,
    output logic HOST_WAIT,
    output logic DISPLAY_RUN
);
    localparam int CW = prbc_pkg::CNT_W;

    prbc_pkg::prbc_pins_t pins_raw;
    prbc_pkg::prbc_pins_t pins_s;
    prbc_pkg::prbc_state_t state;
    prbc_pkg::prbc_state_t next_state;
    prbc_pkg::prbc_state_t boot_exit;
    prbc_pkg::prbc_ahb_req_t req;
    logic [CW-1:0] cnt;
    logic [CW-1:0] cnt_load;
    logic [CW-1:0] fast_count;
    logic por_q;
    logic boot_mode;
    logic boot_aux;
    logic soft_park;
    logic host_go;
    logic data_wr;
    logic [31:0] rd_value;
    logic [31:0] status_word;

    // ---------------------------------------------------------------
    // pin synchronisation
    // ---------------------------------------------------------------
    assign pins_raw = '{
        park_request_n: PARK_REQUEST_N,
        power_on_reset_n: POWER_ON_RESET_N,
        fast_park_n: FAST_PARK_N,
        boot_mode_strap: BOOT_MODE_STRAP,
        boot_aux_strap: BOOT_AUX_STRAP,
        test_port_reset_n: TEST_PORT_RESET_N,
        debug_mode_select: DEBUG_MODE_SELECT
    };

    // every pin passes two flops before use
    prbc_sync #(
        .WIDTH($bits(prbc_pkg::prbc_pins_t))
    ) u_sync (
        .clk(CLOCK),
        .rst_n(RST_N),
        .en(CLK_EN),
        .d(pins_raw),
        .q(pins_s)
    );

    // ---------------------------------------------------------------
    // sequencing decode
    // ---------------------------------------------------------------
    wire por_on = pins_s.power_on_reset_n;
    wire por_rise = por_on & ~por_q;
    wire fast_req = ~pins_s.fast_park_n;
    wire park_req = ~pins_s.park_request_n | soft_park;
    wire cnt_done = (cnt == '0);
    // aux strap high is treated like the wait-for-host strap
    wire wait_boot = boot_mode | boot_aux;

    // after boot the mirrors stay parked while any park is asked for
    assign boot_exit = (park_req | fast_req) ? prbc_pkg::ST_PARKED
                                             : prbc_pkg::ST_RUN;

    assign cnt_load =
        (next_state == prbc_pkg::ST_CONFIG) ? CW'(CONFIG_CYCLES - 1) :
        (next_state == prbc_pkg::ST_PARKING) ? CW'(NORMAL_PARK_CYCLES - 1) :
        CW'(FAST_PARK_CYCLES - 1);

    // next state; reset pin low overrides everything
    always_comb begin
        next_state = state;
        if (!por_on) begin
            next_state = prbc_pkg::ST_OFF;
        end else begin
            case (state)
                prbc_pkg::ST_OFF: begin
                    if (por_rise) next_state = prbc_pkg::ST_CONFIG;
                end
                prbc_pkg::ST_CONFIG: begin
                    if (cnt_done) begin
                        next_state = wait_boot ? prbc_pkg::ST_WAIT_HOST
                                               : boot_exit;
                    end
                end
                prbc_pkg::ST_WAIT_HOST: begin
                    if (host_go) next_state = boot_exit;
                end
                prbc_pkg::ST_RUN: begin
                    if (fast_req) begin
                        next_state = prbc_pkg::ST_FAST_PARK;
                    end else if (park_req) begin
                        next_state = prbc_pkg::ST_PARKING;
                    end
                end
                prbc_pkg::ST_PARKING: begin
                    if (fast_req) begin
                        next_state = prbc_pkg::ST_FAST_PARK;
                    end else if (cnt_done) begin
                        next_state = prbc_pkg::ST_PARKED;
                    end
                end
                prbc_pkg::ST_FAST_PARK: begin
                    if (cnt_done) next_state = prbc_pkg::ST_PARKED;
                end
                prbc_pkg::ST_PARKED: begin
                    // parked only; powering the array down is not ours
                    if (!park_req && !fast_req) begin
                        next_state = prbc_pkg::ST_RUN;
                    end
                end
                default: next_state = prbc_pkg::ST_OFF;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // state, timer and strap capture
    // ---------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            state <= prbc_pkg::ST_OFF;
            cnt <= '0;
            por_q <= 1'b0;
        end else if (CLK_EN) begin
            state <= next_state;
            por_q <= por_on;
            if (next_state != state) cnt <= cnt_load;
            else if (!cnt_done) cnt <= cnt - CW'(1);
        end
    end

    // straps read once, at the reset release edge
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            boot_mode <= 1'b0;
            boot_aux <= 1'b0;
        end else if (CLK_EN && por_rise) begin
            boot_mode <= pins_s.boot_mode_strap;
            boot_aux <= pins_s.boot_aux_strap;
        end
    end

    // outputs follow next state so they come straight from flops
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            MIRROR_PARK_BUSY <= 1'b0;
            MIRROR_PARKED <= 1'b0;
            FAST_PARK_BUSY <= 1'b0;
            SELF_CONFIG_BUSY <= 1'b0;
            HOST_WAIT <= 1'b0;
            DISPLAY_RUN <= 1'b0;
        end else if (CLK_EN) begin
            MIRROR_PARK_BUSY <= (next_state == prbc_pkg::ST_PARKING);
            MIRROR_PARKED <= (next_state == prbc_pkg::ST_PARKED);
            FAST_PARK_BUSY <= (next_state == prbc_pkg::ST_FAST_PARK);
            SELF_CONFIG_BUSY <= (next_state == prbc_pkg::ST_CONFIG);
            HOST_WAIT <= (next_state == prbc_pkg::ST_WAIT_HOST);
            DISPLAY_RUN <= (next_state == prbc_pkg::ST_RUN);
        end
    end

    // fast parks wear the array, so software can watch how many occur
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            fast_count <= '0;
        end else if (CLK_EN && next_state == prbc_pkg::ST_FAST_PARK &&
                     state != prbc_pkg::ST_FAST_PARK && ~&fast_count) begin
            fast_count <= fast_count + CW'(1);
        end
    end

    // ---------------------------------------------------------------
    // AHB-Lite slave, zero wait states, always OKAY
    // ---------------------------------------------------------------
    wire ahb_take = HSEL & HREADY & HTRANS[1];
    assign data_wr = req.write;
    wire wr_ctrl = data_wr && (req.addr == prbc_pkg::REG_CTRL);

    assign status_word = {
        24'h000000,
        soft_park,
        pins_s.debug_mode_select,
        pins_s.test_port_reset_n,
        boot_aux,
        boot_mode,
        state
    };

    assign rd_value =
        (HADDR[7:0] == prbc_pkg::REG_CTRL) ?
            32'(soft_park) << prbc_pkg::CTRL_SOFT_PARK_BIT :
        (HADDR[7:0] == prbc_pkg::REG_STATUS) ? status_word :
        (HADDR[7:0] == prbc_pkg::REG_FAST_COUNT) ? 32'(fast_count) :
        32'h00000000;

    // address phase captured; read data launched for the data phase
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            req <= '0;
            HRDATA <= 32'h00000000;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end else if (CLK_EN) begin
            req.write <= ahb_take & HWRITE;
            req.addr <= HADDR[7:0];
            if (ahb_take && !HWRITE) HRDATA <= rd_value;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end
    end

    // control register; go is a one-cycle command, soft park a level
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            soft_park <= prbc_pkg::CTRL_SOFT_PARK_RESET;
            host_go <= 1'b0;
        end else if (CLK_EN) begin
            host_go <= wr_ctrl & HWDATA[prbc_pkg::CTRL_GO_BIT];
            if (wr_ctrl) soft_park <= HWDATA[prbc_pkg::CTRL_SOFT_PARK_BIT];
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    sequence s_run_fast;
        CLK_EN && por_on && fast_req && state == prbc_pkg::ST_RUN;
    endsequence

    sequence s_fast_out;
        state == prbc_pkg::ST_FAST_PARK && FAST_PARK_BUSY && !DISPLAY_RUN;
    endsequence

    a_park_entry: assert property (
        (CLK_EN && por_on && park_req && !fast_req &&
         state == prbc_pkg::ST_RUN) |=> MIRROR_PARK_BUSY && !DISPLAY_RUN)
        else $error("park request did not start parking");

    a_park_finish: assert property (
        (CLK_EN && por_on && !fast_req && cnt_done &&
         state == prbc_pkg::ST_PARKING) |=> MIRROR_PARKED)
        else $error("normal park did not end parked");

    a_config_start: assert property (
        (CLK_EN && state == prbc_pkg::ST_OFF && por_rise)
        |=> SELF_CONFIG_BUSY && state == prbc_pkg::ST_CONFIG)
        else $error("reset release did not start configuration");

    a_reset_idle: assert property (
        (CLK_EN && !por_on) |=> !(MIRROR_PARK_BUSY || MIRROR_PARKED ||
        FAST_PARK_BUSY || SELF_CONFIG_BUSY || HOST_WAIT || DISPLAY_RUN))
        else $error("output active while power-on reset asserted");

    a_fast_entry: assert property (s_run_fast |=> s_fast_out)
        else $error("fast park input did not start fast park");

    a_fast_bound: assert property (
        state == prbc_pkg::ST_FAST_PARK |-> cnt < CW'(FAST_PARK_CYCLES))
        else $error("fast park timer beyond its length");

    a_boot_wait: assert property (
        (CLK_EN && por_on && boot_mode && cnt_done &&
         state == prbc_pkg::ST_CONFIG) |=> HOST_WAIT ##1 !DISPLAY_RUN)
        else $error("strap high did not wait for host");

    a_strap_latch: assert property (
        (CLK_EN && por_rise) |=> boot_mode == $past(BOOT_MODE_STRAP, 3))
        else $error("boot strap not latched at reset release");

    a_boot_normal: assert property (
        (CLK_EN && por_on && !boot_mode && !boot_aux && !park_req &&
         !fast_req && cnt_done && state == prbc_pkg::ST_CONFIG)
        |=> DISPLAY_RUN)
        else $error("low straps did not boot normally");

endmodule : prbc_top
`default_nettype wire

// file: dv/prbc_host_model.sv
/*
 Host and power controller model: drives the park, fast park, power-on
 reset, strap, test reset and debug pins. Assumes the bench calls its
 tasks just after a rising edge of the shared clock.
*/
`timescale 1ns/1ps
`default_nettype none
module prbc_host_model #(
    parameter int HOLD_CYC = 4_000_000
) (
    input wire logic clk,
    output logic park_request_n,
    output logic power_on_reset_n,
    output logic fast_park_n,
    output logic boot_mode_strap,
    output logic boot_aux_strap,
    output logic test_port_reset_n,
    output logic debug_mode_select
);
    int cyc = 0;
    int last = 0;
    // ---------------------------------------------------------------
    // pin levels
    // ---------------------------------------------------------------
    // reset stays low until the bench says supplies and clocks are up
    initial begin
        park_request_n = 1'b1;
        power_on_reset_n = 1'b0;
        fast_park_n = 1'b1;
        boot_mode_strap = 1'b0;
        boot_aux_strap = 1'b0;
        test_port_reset_n = 1'b0;
        debug_mode_select = 1'b1;
    end
    // free cycle count, to time the park request hold
    always @(posedge clk) begin
        cyc <= cyc + 1;
    end
    // park request; waits out the minimum level hold (scaled down)
    task automatic park(input logic lvl);
        while (cyc - last < HOLD_CYC) @(posedge clk);
        park_request_n <= lvl;
        last = cyc;
    endtask : park
    // used to cut into a normal park and to fast park from run
    task automatic fast(input logic lvl);
        fast_park_n <= lvl;
    endtask : fast
    task automatic por(input logic lvl);
        power_on_reset_n <= lvl;
    endtask : por
    // debug use only; the board keeps these at their normal levels
    task automatic dbg(input logic t, input logic d);
        test_port_reset_n <= t;
        debug_mode_select <= d;
    endtask : dbg
    task automatic straps(input logic m, input logic a);
        boot_mode_strap <= m;
        boot_aux_strap <= a;
    endtask : straps
endmodule : prbc_host_model
`default_nettype wire

// file: dv/prbc_tb_top.sv
/*
 Self-checking bench for the park, reset and boot block: AHB-Lite
 register tasks, pin sequences through the host model. Assumes a single
 slave, so HREADY is the block's own HREADYOUT.
*/
`timescale 1ns/1ps
`default_nettype none
module prbc_tb_top;
    localparam int CFG = 8;
    localparam int NPK = 16;
    localparam int FPK = 4;
    localparam int MPB = 0;
    localparam int SCB = 3;
    localparam int HWT = 4;
    localparam int DRN = 5;
    logic CLOCK = 1'b0;
    logic RST_N = 1'b0;
    logic HSEL = 1'b0;
    logic [31:0] HADDR = 32'h0;
    logic [1:0] HTRANS = 2'h0;
    logic HWRITE = 1'b0;
    logic [31:0] HWDATA = 32'h0;
    logic [2:0] HSIZE = 3'h0;
    logic CLK_EN = 1'b1;
    wire logic [31:0] HRDATA;
    wire logic HREADYOUT, HRESP, MPBS, MPKD, FPBS, SCBS, HWAIT, DRUN;
    wire logic PRQ, POR, FPK_N, BMS, BAS, TRS, DMS;
    wire logic [5:0] outs = {DRUN, HWAIT, SCBS, FPBS, MPKD, MPBS};
    int err_total = 0;
    int checks = 0;
    int n;
    logic [31:0] rv;

    // ---------------------------------------------------------------
    // clock, design and far side
    // ---------------------------------------------------------------
    initial begin
        forever #25 CLOCK = ~CLOCK;
    end
    prbc_top #(.CONFIG_CYCLES(CFG), .NORMAL_PARK_CYCLES(NPK),
        .FAST_PARK_CYCLES(FPK)) u_prbc_top (.CLOCK(CLOCK), .RST_N(RST_N),
        .CLK_EN(CLK_EN), .PARK_REQUEST_N(PRQ), .POWER_ON_RESET_N(POR),
        .FAST_PARK_N(FPK_N), .BOOT_MODE_STRAP(BMS), .BOOT_AUX_STRAP(BAS),
        .TEST_PORT_RESET_N(TRS), .DEBUG_MODE_SELECT(DMS), .HSEL(HSEL),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
        .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .MIRROR_PARK_BUSY(MPBS),
        .MIRROR_PARKED(MPKD), .FAST_PARK_BUSY(FPBS),
        .SELF_CONFIG_BUSY(SCBS), .HOST_WAIT(HWAIT), .DISPLAY_RUN(DRUN));
    prbc_host_model #(.HOLD_CYC(40)) u_prbc_host_model (.clk(CLOCK),
        .park_request_n(PRQ), .power_on_reset_n(POR), .fast_park_n(FPK_N),
        .boot_mode_strap(BMS), .boot_aux_strap(BAS),
        .test_port_reset_n(TRS), .debug_mode_select(DMS));

    // ---------------------------------------------------------------
    // compare, bus and wait tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_pins(input logic [5:0] exp);
        chk({26'h0, outs}, {26'h0, exp});
    endtask : chk_pins
    // address phase held until hready, then data phase until hready
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= w;
        HSIZE <= 3'h2;
        HADDR <= {24'h0, a};
        do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
        rv = HRDATA;
    endtask : xfer
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rv, exp);
        chk({31'h0, HRESP}, 32'h0);
    endtask : rd_chk
    // edges until an output reaches a level; bounded
    task automatic wait_out(input int idx, input logic lvl);
        n = 0;
        do begin
            @(posedge CLOCK);
            n++;
        end while (outs[idx] !== lvl && n < 300);
        if (n >= 300) chk({31'h0, outs[idx]}, {31'h0, lvl});
    endtask : wait_out
    task automatic summarize();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial begin
        repeat (12) @(posedge CLOCK);
        RST_N <= 1'b1;
        repeat (20) @(posedge CLOCK);
        chk_pins(6'h00);
        rd_chk(prbc_pkg::REG_STATUS, 32'h40);
        // test reset and debug select are only reported, through the sync
        u_prbc_host_model.dbg(1'b1, 1'b0);
        repeat (3) @(posedge CLOCK);
        rd_chk(prbc_pkg::REG_STATUS, 32'h20);
        u_prbc_host_model.dbg(1'b0, 1'b1);
        repeat (3) @(posedge CLOCK);
        rd_chk(prbc_pkg::REG_FAST_COUNT, 32'h0);
        xfer(1'b1, 8'h3c, 32'hffff_ffff);
        rd_chk(8'h3c, 32'h0);
        $display("test held_reset done");
        // boot with both straps low
        u_prbc_host_model.por(1'b1);
        wait_out(SCB, 1'b1);
        chk({31'h0, n >= 3}, 32'h1);
        wait_out(SCB, 1'b0);
        chk(n, CFG);
        chk_pins(6'h20);
        rd_chk(prbc_pkg::REG_STATUS, 32'h43);
        $display("test normal_boot done");
        // normal park, then fast park cutting into a second one
        u_prbc_host_model.park(1'b0);
        @(posedge CLOCK);
        chk_pins(6'h20);
        wait_out(MPB, 1'b1);
        chk_pins(6'h01);
        wait_out(MPB, 1'b0);
        chk(n, NPK);
        chk_pins(6'h02);
        u_prbc_host_model.park(1'b1);
        wait_out(DRN, 1'b1);
        u_prbc_host_model.park(1'b0);
        wait_out(MPB, 1'b1);
        u_prbc_host_model.fast(1'b0);
        wait_out(2, 1'b1);
        chk_pins(6'h04);
        wait_out(2, 1'b0);
        chk({31'h0, n <= FPK}, 32'h1);
        chk_pins(6'h02);
        rd_chk(prbc_pkg::REG_FAST_COUNT, 32'h1);
        u_prbc_host_model.fast(1'b1);
        u_prbc_host_model.park(1'b1);
        wait_out(DRN, 1'b1);
        $display("test parking done");
        // soft park through the control register
        xfer(1'b1, prbc_pkg::REG_CTRL, 32'h2);
        wait_out(1, 1'b1);
        rd_chk(prbc_pkg::REG_STATUS, 32'hc6);
        xfer(1'b1, prbc_pkg::REG_CTRL, 32'h0);
        wait_out(DRN, 1'b1);
        $display("test soft_park done");
        // frozen clock enable holds a fast park off; then it runs from RUN
        CLK_EN <= 1'b0;
        u_prbc_host_model.fast(1'b0);
        repeat (10) @(posedge CLOCK);
        chk_pins(6'h20);
        CLK_EN <= 1'b1;
        wait_out(2, 1'b1);
        chk_pins(6'h04);
        wait_out(2, 1'b0);
        chk_pins(6'h02);
        u_prbc_host_model.fast(1'b1);
        wait_out(DRN, 1'b1);
        rd_chk(prbc_pkg::REG_FAST_COUNT, 32'h2);
        $display("test fast_from_run done");
        // reboot with each strap high in turn
        for (int s = 0; s < 2; s++) begin
            u_prbc_host_model.por(1'b0);
            wait_out(DRN, 1'b0);
            chk_pins(6'h00);
            u_prbc_host_model.straps(s == 0, s == 1);
            u_prbc_host_model.por(1'b1);
            wait_out(HWT, 1'b1);
            chk_pins(6'h10);
            rd_chk(prbc_pkg::REG_STATUS, s ? 32'h52 : 32'h4a);
            xfer(1'b1, prbc_pkg::REG_CTRL, 32'h1);
            wait_out(DRN, 1'b1);
            rd_chk(prbc_pkg::REG_CTRL, 32'h0);
        end
        $display("test strap_boot done");
        // board reset in mid-run: outputs clear at once, then a fresh boot
        u_prbc_host_model.straps(1'b0, 1'b0);
        RST_N <= 1'b0;
        repeat (2) @(posedge CLOCK);
        chk_pins(6'h00);
        RST_N <= 1'b1;
        wait_out(DRN, 1'b1);
        rd_chk(prbc_pkg::REG_STATUS, 32'h43);
        $display("test mid_reset done");
        summarize();
    end
    // watchdog: the tests need well under 3000 cycles
    initial begin
        repeat (20000) @(posedge CLOCK);
        err_total++;
        summarize();
    end
endmodule : prbc_tb_top
`default_nettype wire
